// ===== logic/odc_core.sv
// octal dac channel core: staging/output registers, loads, modes, monitor
// assumes an apb master on pclk and an asynchronous load pin
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "odc_defs.svh"
module odc_core
    import odc_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    input  wire logic         load_strobe_n,
    output logic [127:0]      dac_code,
    output logic [15:0]       channel_output_mode,
    output logic [7:0]        output_active,
    output logic [7:0]        output_span,
    output logic              int_ref_enable,
    output logic [4:0]        monitor_source_select,
    output odc_mon_t          monitor_route
);
    // ==========================================================
    // functions
    function automatic logic mon_valid(input logic [4:0] code);
        return code <= `ODC_MON_LAST;
    endfunction : mon_valid

    function automatic odc_mon_t mon_kind(input logic [4:0] code);
        if (code == `ODC_MON_TEMP)
            return ODC_MON_TEMP;
        else if (code < `ODC_MON_CURR_BASE)
            return ODC_MON_VOLT;
        else if (code <= `ODC_MON_CURR_LAST)
            return ODC_MON_CURR;
        else
            return ODC_MON_OFF;
    endfunction : mon_kind

    // ==========================================================
    // state
    odc_code_t   stage_q [`ODC_NCH];
    odc_code_t   out_q   [`ODC_NCH];
    logic [7:0]  bst_mask_q;
    logic [7:0]  bout_mask_q;
    logic [7:0]  pin_mask_q;
    logic [7:0]  soft_mask_q;
    logic        err_q;
    logic        err_d;
    logic        pin_prev_q;
    odc_gap_t    gap_q;
    odc_gap_t    gap_d;
    logic [31:0] rd_data;

    // ==========================================================
    // apb decode
    logic       acc;
    logic       acc_wr;
    logic       acc_rd0;
    logic       sel_stage;
    logic       sel_out;
    logic [2:0] ch;
    logic       mapped;
    logic       wr_ok;

    assign acc       = psel & penable;
    assign acc_rd0   = acc & ~pready;
    assign sel_stage = paddr[7:5] == `ODC_STAGE_BASE && paddr[1:0] == 2'h0;
    assign sel_out   = paddr[7:5] == `ODC_OUT_BASE && paddr[1:0] == 2'h0;
    assign ch        = paddr[4:2];
    assign mapped    = sel_stage | sel_out | (paddr <= `ODC_A_BOUT_WORD && paddr[1:0] == 2'h0);
    assign acc_wr    = acc & pready & pwrite & mapped;
    assign wr_ok     = acc_wr;

    logic w_mode;
    logic w_span;
    logic w_ref;
    logic w_mon;
    logic w_bstm;
    logic w_boutm;
    logic w_pinm;
    logic w_softm;
    logic w_trig;
    logic w_stat;
    logic w_bst;
    logic w_bout;

    assign w_mode  = wr_ok && paddr == `ODC_A_MODE;
    assign w_span  = wr_ok && paddr == `ODC_A_SPAN;
    assign w_ref   = wr_ok && paddr == `ODC_A_REF;
    assign w_mon   = wr_ok && paddr == `ODC_A_MON;
    assign w_bstm  = wr_ok && paddr == `ODC_A_BST_MASK;
    assign w_boutm = wr_ok && paddr == `ODC_A_BOUT_MASK;
    assign w_pinm  = wr_ok && paddr == `ODC_A_PIN_MASK;
    assign w_softm = wr_ok && paddr == `ODC_A_SOFT_MASK;
    assign w_trig  = wr_ok && paddr == `ODC_A_TRIG;
    assign w_stat  = wr_ok && paddr == `ODC_A_STATUS;
    assign w_bst   = wr_ok && paddr == `ODC_A_BST_WORD;
    assign w_bout  = wr_ok && paddr == `ODC_A_BOUT_WORD;

    // ==========================================================
    // load pin and triggers
    logic pin_sync;
    logic pin_fall;
    logic pin_low;
    logic soft_fire;

    odc_sync u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_in   (load_strobe_n),
        .pin_sync (pin_sync)
    );

    assign pin_fall  = pin_prev_q & ~pin_sync;
    assign pin_low   = ~pin_sync;
    assign soft_fire = w_trig & (pwdata[`ODC_TRIG_A_BIT] | pwdata[`ODC_TRIG_B_BIT]);

    // ==========================================================
    // per-channel update paths
    logic [7:0] want;
    logic [7:0] stage_wr;
    logic       gap_free;
    logic       upd_any;
    logic       upd_fail;
    odc_code_t  upd_val [`ODC_NCH];

    assign gap_free = gap_q == '0;

    genvar n;
    generate
        for (n = 0; n < `ODC_NCH; n++) begin : g_ch
            logic wr_out;
            logic bc_out;
            logic load;
            logic trans;
            assign wr_out      = wr_ok & sel_out & (ch == 3'(n));
            assign bc_out      = w_bout & bout_mask_q[n];
            assign stage_wr[n] = (wr_ok & sel_stage & (ch == 3'(n))) | (w_bst & bst_mask_q[n]);
            assign load        = (pin_fall & pin_mask_q[n]) | (soft_fire & soft_mask_q[n]);
            assign trans       = stage_wr[n] & pin_low & pin_mask_q[n];
            assign want[n]     = wr_out | bc_out | load | trans;
            assign upd_val[n]  = (wr_out | bc_out | trans) ? pwdata[15:0] : stage_q[n];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage_q[n] <= '0;
                    out_q[n]   <= '0;
                end else begin
                    if (stage_wr[n])
                        stage_q[n] <= pwdata[15:0];
                    if (want[n] & gap_free)
                        out_q[n] <= upd_val[n];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    dac_code[16*n +: 16] <= '0;
                else if (want[n] & gap_free)
                    dac_code[16*n +: 16] <= upd_val[n];
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    output_active[n] <= 1'b0;
                else
                    output_active[n] <= odc_mode_t'(channel_output_mode[2*n +: 2]) == ODC_MODE_NORMAL;
            end
        end
    endgenerate

    // ==========================================================
    // update spacing guard and error flag
    assign upd_any  = |want;
    assign upd_fail = upd_any & ~gap_free;
    assign gap_d    = (upd_any & gap_free) ? odc_gap_t'(`ODC_UPD_GAP_CYC - 1)
                    : (gap_free ? gap_q : gap_q - 6'h01);
    assign err_d    = upd_fail | (err_q & ~(w_stat & pwdata[`ODC_ST_ERR_BIT]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q      <= '0;
            err_q      <= 1'b0;
            pin_prev_q <= 1'b1;
        end else begin
            gap_q      <= gap_d;
            err_q      <= err_d;
            pin_prev_q <= pin_sync;
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_output_mode   <= `ODC_MODE_RST;
            output_span           <= '0;
            int_ref_enable        <= 1'b0;
            monitor_source_select <= '0;
            monitor_route         <= ODC_MON_VOLT;
            bst_mask_q            <= '0;
            bout_mask_q           <= '0;
            pin_mask_q            <= `ODC_MASK_RST;
            soft_mask_q           <= `ODC_MASK_RST;
        end else begin
            if (w_mode)
                channel_output_mode <= pwdata[15:0];
            if (w_span)
                output_span <= pwdata[7:0];
            if (w_ref)
                int_ref_enable <= pwdata[0];
            if (w_mon && mon_valid(pwdata[4:0])) begin
                monitor_source_select <= pwdata[4:0];
                monitor_route         <= mon_kind(pwdata[4:0]);
            end
            if (w_bstm)
                bst_mask_q <= pwdata[7:0];
            if (w_boutm)
                bout_mask_q <= pwdata[7:0];
            if (w_pinm)
                pin_mask_q <= pwdata[7:0];
            if (w_softm)
                soft_mask_q <= pwdata[7:0];
        end
    end

    // ==========================================================
    // read mux and apb answer
    always_comb begin
        rd_data = '0;
        if (sel_stage)
            rd_data[15:0] = stage_q[ch];
        else if (sel_out)
            rd_data[15:0] = out_q[ch];
        else begin
            unique case (paddr)
                `ODC_A_MODE:      rd_data[15:0] = channel_output_mode;
                `ODC_A_SPAN:      rd_data[7:0]  = output_span;
                `ODC_A_REF:       rd_data[0]    = int_ref_enable;
                `ODC_A_MON:       rd_data[4:0]  = monitor_source_select;
                `ODC_A_BST_MASK:  rd_data[7:0]  = bst_mask_q;
                `ODC_A_BOUT_MASK: rd_data[7:0]  = bout_mask_q;
                `ODC_A_PIN_MASK:  rd_data[7:0]  = pin_mask_q;
                `ODC_A_SOFT_MASK: rd_data[7:0]  = soft_mask_q;
                `ODC_A_STATUS:    rd_data[2:0]  = {~gap_free, pin_sync, err_q};
                default:          rd_data       = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc_rd0;
            pslverr <= acc_rd0 & ~mapped;
            if (acc_rd0)
                prdata <= (pwrite | ~mapped) ? 32'h0000_0000 : rd_data;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pin_fall2;
        pin_fall && pin_mask_q[2] && gap_free && !g_ch[2].wr_out && !g_ch[2].bc_out && !stage_wr[2];
    endsequence

    sequence s_soft_fire1;
        soft_fire && soft_mask_q[1] && gap_free && !g_ch[1].wr_out && !g_ch[1].bc_out && !stage_wr[1];
    endsequence

    sequence s_trans6;
        stage_wr[6] && pin_low && pin_mask_q[6] && gap_free;
    endsequence

    sequence s_pin_skip4;
        pin_fall && !pin_mask_q[4] && !soft_fire && !g_ch[4].wr_out && !g_ch[4].bc_out;
    endsequence

    a_span_store: assert property (w_span |=> output_span == $past(pwdata[7:0]))
        else $error("span bits not stored");
    a_direct_out: assert property (g_ch[1].wr_out && gap_free |=>
        out_q[1] == $past(pwdata[15:0]) && stage_q[1] == $past(stage_q[1]))
        else $error("direct output write wrong");
    a_code_pin: assert property (##1 dac_code[31:16] == out_q[1])
        else $error("code pins differ from output register");
    a_mode_active: assert property (w_mode && pwdata[1:0] == 2'h3 |=> ##1 !output_active[0])
        else $error("powered-down channel still active");
    a_ref_enable: assert property (w_ref |=> int_ref_enable == $past(pwdata[0]))
        else $error("reference enable not stored");
    a_mon_invalid: assert property (w_mon && !mon_valid(pwdata[4:0]) |=> $stable(monitor_source_select))
        else $error("invalid monitor code accepted");
    a_mon_temp: assert property (w_mon && pwdata[4:0] == `ODC_MON_TEMP |=> monitor_route == ODC_MON_TEMP)
        else $error("temperature not routed");
    a_bcast_stage: assert property (w_bst && bst_mask_q[2] |=> stage_q[2] == $past(pwdata[15:0]))
        else $error("broadcast staging missed channel");
    a_update_err: assert property (upd_any && !gap_free |=> err_q)
        else $error("failed update did not flag");
    a_pin_load: assert property (s_pin_fall2 |=> out_q[2] == $past(stage_q[2]))
        else $error("pin load did not transfer");
    a_soft_mask: assert property (soft_fire && !soft_mask_q[3] && !want[3] |=> $stable(out_q[3]))
        else $error("masked channel took soft load");

    // ==========================================================
    // assertions: stores, loads, guard and bus answer
    a_mode_store: assert property (w_mode |=> channel_output_mode == $past(pwdata[15:0]))
        else $error("mode field not stored");
    a_mon_store: assert property (w_mon && mon_valid(pwdata[4:0]) |=> monitor_source_select == $past(pwdata[4:0]))
        else $error("valid monitor code not stored");
    a_route_volt: assert property (monitor_source_select < `ODC_MON_CURR_BASE |-> monitor_route == ODC_MON_VOLT)
        else $error("voltage code not routed as voltage");
    a_temp_only: assert property (monitor_route == ODC_MON_TEMP |-> monitor_source_select == `ODC_MON_TEMP)
        else $error("temperature route without its code");
    a_stage_store: assert property (wr_ok && sel_stage && ch == 3'h5 |=> stage_q[5] == $past(pwdata[15:0]))
        else $error("staging write not stored");
    a_bcast_out: assert property (w_bout && bout_mask_q[5] && gap_free |=> out_q[5] == $past(pwdata[15:0]))
        else $error("broadcast output missed channel");
    a_fail_hold: assert property (upd_fail |=> $stable(dac_code))
        else $error("failed update changed a code");
    a_err_clear: assert property (w_stat && pwdata[`ODC_ST_ERR_BIT] && !upd_fail |=> !err_q)
        else $error("error flag not cleared");
    a_guard_start: assert property (upd_any && gap_free |=> gap_q == odc_gap_t'(`ODC_UPD_GAP_CYC - 1))
        else $error("update guard not started");
    a_stage_transp: assert property (s_trans6 |=> out_q[6] == $past(pwdata[15:0]))
        else $error("low load pin did not pass staging write");
    a_pin_mask: assert property (s_pin_skip4 |=> $stable(out_q[4]))
        else $error("masked channel took pin load");
    a_soft_load: assert property (s_soft_fire1 |=> out_q[1] == $past(stage_q[1]))
        else $error("soft load did not transfer");
    a_ready_once: assert property (acc_rd0 |=> pready ##1 !pready)
        else $error("bus answer not a single cycle");
endmodule : odc_core
`default_nettype wire

// ===== logic/odc_defs.svh
// constants of the octal dac channel core: offsets, fields, resets, timing
// assumes 32-bit apb with byte addresses on paddr[7:0]
//
// Notes on behaviour
// - per-channel span bit: clear gain one, set two
// - output codes are unsigned straight binary 16-bit
// - 2-bit mode: normal, 1k, 7.7k, 32k off
// - modes reset to 3, amplifier off
// - powered-down modes keep registers fully usable
// - reference is input after reset; bit enables internal
// - monitor selects one of 27 sources
// - invalid monitor select write is ignored
// - monitor code 0x19 routes die temperature
// - eight channels, each staging and output register
// - direct output write acts now, staging untouched
// - broadcast staging write fills masked channels
// - broadcast output write fills masked channels
// - failed output update sets readable error flag
// - load copies selected staging to output together
// - load pin falls: load; low: staging transparent
// - pin load mask, resets all ones
// - soft trigger a or b starts the load
// - soft load mask, resets all ones
`ifndef ODC_DEFS_SVH
`define ODC_DEFS_SVH

`define ODC_NCH            8
`define ODC_A_MODE         8'h00
`define ODC_A_SPAN         8'h04
`define ODC_A_REF          8'h08
`define ODC_A_MON          8'h0c
`define ODC_A_BST_MASK     8'h10
`define ODC_A_BOUT_MASK    8'h14
`define ODC_A_PIN_MASK     8'h18
`define ODC_A_SOFT_MASK    8'h1c
`define ODC_A_TRIG         8'h20
`define ODC_A_STATUS       8'h24
`define ODC_A_BST_WORD     8'h28
`define ODC_A_BOUT_WORD    8'h2c
`define ODC_STAGE_BASE     3'h2
`define ODC_OUT_BASE       3'h3

`define ODC_MODE_RST       16'hffff
`define ODC_MASK_RST       8'hff
`define ODC_MON_TEMP       5'h19
`define ODC_MON_LAST       5'h1a
`define ODC_MON_CURR_BASE  5'h08
`define ODC_MON_CURR_LAST  5'h0f

`define ODC_TRIG_A_BIT     0
`define ODC_TRIG_B_BIT     1
`define ODC_ST_ERR_BIT     0

`define ODC_CLK_NS         20
`define ODC_UPD_GAP_NS     640
`define ODC_UPD_GAP_CYC    ((`ODC_UPD_GAP_NS + `ODC_CLK_NS - 1) / `ODC_CLK_NS)

`endif

// ===== logic/odc_pkg.sv
// types of the octal dac channel core
// assumes odc_defs.svh for all numeric constants
package odc_pkg;
    typedef logic [15:0] odc_code_t;
    typedef logic [5:0]  odc_gap_t;
    typedef enum logic [1:0] {
        ODC_MODE_NORMAL,
        ODC_MODE_PD_1K,
        ODC_MODE_PD_7K7,
        ODC_MODE_PD_32K
    } odc_mode_t;
    typedef enum logic [1:0] {
        ODC_MON_OFF,
        ODC_MON_VOLT,
        ODC_MON_CURR,
        ODC_MON_TEMP
    } odc_mon_t;
endpackage : odc_pkg

// ===== logic/odc_sync.sv
// two-flop synchroniser for a pin level
// assumes the pin idles high
`timescale 1ns/10ps
`default_nettype none
module odc_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_in,
    output logic      pin_sync
);
    logic meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            meta_q   <= pin_in;
            pin_sync <= meta_q;
        end
    end
endmodule : odc_sync
`default_nettype wire

// ===== tb/odc_load_pin.sv
// partner model: host side pulsing the load pin from its own 160 ns clock
// assumes fire is held high by the bench until done rises
`timescale 1ns/10ps
`default_nettype none
module odc_load_pin (
    input  wire logic fire,
    output logic      load_strobe_n,
    output logic      done
);
    logic lclk;
    initial begin
        lclk = 1'b0;
        load_strobe_n = 1'b1;
        done = 1'b0;
        #7;
        forever #80 lclk = ~lclk;
    end
    // one link cycle low per request, idle high otherwise
    always @(posedge lclk) begin
        if (fire && !done && load_strobe_n) begin
            load_strobe_n <= 1'b0;
        end else if (!load_strobe_n) begin
            load_strobe_n <= 1'b1;
            done          <= 1'b1;
        end else if (!fire) begin
            done <= 1'b0;
        end
    end
endmodule : odc_load_pin
`default_nettype wire

// ===== tb/test_odc_core.sv
// testbench of the octal dac channel core over apb
// assumes odc_defs.svh and odc_pkg on the include and compile paths
`timescale 1ns/10ps
`default_nettype none
`include "odc_defs.svh"
module test_odc_core;
    import odc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fire, pin_n, pin_done;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, seed;
    logic [127:0] dac_code;
    logic [15:0]  chmode, v;
    logic [7:0]   oact, ospan;
    logic         iref;
    logic [4:0]   msel;
    odc_mon_t     mroute;
    logic [32:0]  notes[$];
    logic [15:0]  exp_out[8], exp_stg[8];
    int           num_errors, comparisons, cycles;
    odc_core odc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .load_strobe_n(pin_n), .dac_code(dac_code), .channel_output_mode(chmode), .output_active(oact),
        .output_span(ospan), .int_ref_enable(iref), .monitor_source_select(msel), .monitor_route(mroute));
    odc_load_pin odc_load_pin_inst (.fire(fire), .load_strobe_n(pin_n), .done(pin_done));
    always #10 pclk = ~pclk;
    // ==========================================================
    // checking
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            results();
        end
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
            check({pslverr, prdata}, notes.pop_front());
        end
    end
    // ==========================================================
    // apb master
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // let the accepting edge settle before anyone looks at outputs
        @(negedge pclk);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        notes.push_back({e, d});
        xfer(a, 1'b0, 32'h0);
    endtask : rd
    task automatic gap();
        repeat (40) @(posedge pclk);
    endtask : gap
    task automatic check_all(input string name);
        logic [127:0] packed_out;
        for (int n = 0; n < 8; n++) begin
            rd(8'h40 + 8'(4 * n), {16'h0, exp_stg[n]}, 1'b0);
            rd(8'h60 + 8'(4 * n), {16'h0, exp_out[n]}, 1'b0);
            packed_out[16 * n +: 16] = exp_out[n];
        end
        check(dac_code, packed_out);
        $display("test %s done", name);
    endtask : check_all
    // ==========================================================
    // scenarios
    initial begin
        {pclk, presetn, psel, penable, pwrite, fire, paddr, pwdata} = '0;
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        for (int n = 0; n < 8; n++) begin
            exp_out[n] = 16'h0;
            exp_stg[n] = 16'h0;
        end
        seed = $urandom(46);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ODC_A_MODE, 32'h0000ffff, 1'b0);
        rd(`ODC_A_SPAN, 32'h0, 1'b0);
        rd(`ODC_A_REF, 32'h0, 1'b0);
        rd(`ODC_A_PIN_MASK, 32'hff, 1'b0);
        rd(`ODC_A_SOFT_MASK, 32'hff, 1'b0);
        rd(8'hfc, 32'h0, 1'b1);
        wr(`ODC_A_MODE, 32'h00e4);
        wr(`ODC_A_SPAN, 32'hff);
        wr(`ODC_A_REF, 32'h1);
        rd(`ODC_A_MODE, 32'h00e4, 1'b0);
        check(oact, 8'hf1);
        check(ospan, 8'hff);
        check(iref, 1'b1);
        wr(`ODC_A_MON, 32'h03);
        check(mroute, ODC_MON_VOLT);
        wr(`ODC_A_MON, 32'h0b);
        check(mroute, ODC_MON_CURR);
        wr(`ODC_A_MON, 32'h19);
        check(mroute, ODC_MON_TEMP);
        wr(`ODC_A_MON, 32'h1f);
        rd(`ODC_A_MON, 32'h19, 1'b0);
        check(msel, 5'h19);
        $display("test modes done");
        // direct output writes, channels 1 to 3 powered down
        for (int n = 0; n < 8; n++) begin
            gap();
            v = 16'($urandom);
            wr(8'h60 + 8'(4 * n), {16'h0, v});
            exp_out[n] = v;
        end
        check_all("direct");
        wr(`ODC_A_BST_MASK, 32'h0f);
        v = 16'($urandom);
        wr(`ODC_A_BST_WORD, {16'h0, v});
        for (int n = 0; n < 4; n++) exp_stg[n] = v;
        check_all("broadcast staging");
        gap();
        wr(`ODC_A_BOUT_MASK, 32'hf0);
        v = 16'($urandom);
        wr(`ODC_A_BOUT_WORD, {16'h0, v});
        for (int n = 4; n < 8; n++) exp_out[n] = v;
        check_all("broadcast output");
        for (int n = 0; n < 2; n++) begin
            wr(`ODC_A_SOFT_MASK, 32'(1 << n));
            gap();
            wr(`ODC_A_TRIG, 32'(1 << n));
            exp_out[n] = exp_stg[n];
        end
        check_all("soft load");
        wr(`ODC_A_PIN_MASK, 32'h04);
        gap();
        fire <= 1'b1;
        while (pin_done !== 1'b1) @(posedge pclk);
        fire <= 1'b0;
        exp_out[2] = exp_stg[2];
        repeat (8) @(posedge pclk);
        check_all("pin load");
        gap();
        wr(8'h60, 32'h1234);
        wr(8'h64, 32'h5678);
        exp_out[0] = 16'h1234;
        rd(`ODC_A_STATUS, 32'h7, 1'b0);
        wr(`ODC_A_STATUS, 32'h1);
        gap();
        rd(`ODC_A_STATUS, 32'h2, 1'b0);
        check_all("update error");
        results();
    end
endmodule : test_odc_core
`default_nettype wire
